/* File: rtl/output_compare_channel_defines.vh */
`ifndef OUTPUT_COMPARE_CHANNEL_DEFINES_VH
`define OUTPUT_COMPARE_CHANNEL_DEFINES_VH
// Byte addresses of the registers on the APB slave.
`define ADDR_CONTROL_ONE 12'h000
`define ADDR_CONTROL_TWO 12'h004
`define ADDR_PRIMARY 12'h008
`define ADDR_SECONDARY 12'h00c
`define ADDR_TIMER 12'h010
`define ADDR_SECONDARY_HI 12'h014
`define ADDR_PRIMARY_HI 12'h018
// Bit positions in the first control register.
`define BIT_CLEAR_MODE 3
`define BIT_MODE_HI 2
`define BIT_MODE_LO 0
// Bit positions in the second control register.
`define BIT_INVERT 12
`define BIT_CASCADE 8
`define BIT_TRIG_FLAG 6
`define BIT_TRISTATE 5
// Writable masks of the control registers.
`define MASK_CONTROL_ONE 16'h000f
`define MASK_CONTROL_TWO 16'hf1ff
// Reset values.
`define RESET_CONTROL_ONE 16'h0000
`define RESET_CONTROL_TWO 16'h000c
`define ZERO16 16'h0000
// Compare mode codes.
`define MODE_OFF 3'h0
`define MODE_SHOT_HIGH 3'h1
`define MODE_SHOT_LOW 3'h2
`define MODE_TOGGLE 3'h3
`define MODE_DOUBLE_SHOT 3'h4
`define MODE_DOUBLE_CONT 3'h5
`define MODE_EDGE_PWM 3'h6
`define MODE_CENTER_PWM 3'h7
`endif

/* File: rtl/compare_match_unit.v */
`timescale 1ns/1ps
// Equality compare of the timer against the two compare values, per bit in a generate loop.
module compare_match_unit
(
  // Operands.
  input wire [31:0] timer_value,
  input wire [31:0] primary_value,
  input wire [31:0] secondary_value,
  // Width select: high when the upper half takes part.
  input wire wide,
  // Results.
  output wire primary_hit,
  output wire secondary_hit,
  output wire zero_hit
);
  // Per-bit equality vectors.
  wire [31:0] eq_p;
  wire [31:0] eq_s;
  wire [31:0] eq_z;
  genvar i;
  // Each bit counts only if it is in the low half or the channel is cascaded.
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_bit
      wire used;
      assign used = (i < 16) ? 1'b1 : wide;
      assign eq_p[i] = ~used | (timer_value[i] == primary_value[i]);
      assign eq_s[i] = ~used | (timer_value[i] == secondary_value[i]);
      assign eq_z[i] = ~used | ~timer_value[i];
    end
  endgenerate
  // All bits equal means a match.
  assign primary_hit = &eq_p;
  assign secondary_hit = &eq_s;
  assign zero_hit = &eq_z;
endmodule

/* File: rtl/output_compare_channel.v */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Clear mode set: secondary match or software clears flag.
// - Clear mode zero: only software clears flag.
// - Mode 111: high on primary, low on secondary.
// - Mode 110: high at zero, low on primary.
// - Mode 101: start low, toggle alternate matches forever.
// - Mode 100: start low, toggle twice, one pulse.
// - Mode 011: toggle on every primary match.
// - Mode 010: start high, low on first match.
// - Mode 001: start low, high on first match.
// - Mode 000: channel disabled, no events.
// - Compare values double-buffered only in PWM modes.
// - Cascade bit joins two channels into 32 bits.
`include "output_compare_channel_defines.vh"
module output_compare_channel
(
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Running timer count, low and high halves.
  input wire [31:0] compare_timer_count,
  // Pin drive; the enable is low while the pin is driven.
  output reg compare_output_pin,
  output reg compare_output_pin_oe_n
);
  // Control registers.
  reg [15:0] compare_control_one_reg;
  reg [15:0] compare_control_two_reg;
  // Compare values as software wrote them.
  reg [31:0] primary_write_reg;
  reg [31:0] secondary_write_reg;
  // Compare values in use by the comparator.
  reg [31:0] primary_compare_value_reg;
  reg [31:0] secondary_compare_value_reg;
  // Mode-generated output level before inversion.
  reg level_reg;
  reg level_next;
  // Phase of the double-compare modes: low waits for primary, high for secondary.
  reg phase_reg;
  reg phase_next;
  // High once a single-shot mode has fired.
  reg done_reg;
  reg done_next;
  // Mode code last seen, to notice a change of mode.
  reg [2:0] last_mode_reg;
  // Decoded fields.
  // Fields that are not decoded here are only stored for software.
  wire [2:0] compare_mode_select;
  wire trigger_status_clear_mode;
  wire cascade_32bit_enable;
  wire output_invert;
  wire output_tristate;
  wire pwm_mode;
  wire mode_change;
  // Match results.
  wire primary_hit;
  wire secondary_hit;
  wire zero_hit;
  // Bus decode.
  wire wr_access;
  wire rd_access;
  wire wr_one;
  wire wr_two;
  // High when the address names a register of this block.
  wire addr_mapped;
  // Timer view, masked to 16 bits unless cascaded.
  wire [31:0] timer_view;
  reg [31:0] read_value;

  // Field decode of the control registers.
  assign compare_mode_select = compare_control_one_reg[`BIT_MODE_HI:`BIT_MODE_LO];
  assign trigger_status_clear_mode = compare_control_one_reg[`BIT_CLEAR_MODE];
  assign cascade_32bit_enable = compare_control_two_reg[`BIT_CASCADE];
  assign output_invert = compare_control_two_reg[`BIT_INVERT];
  assign output_tristate = compare_control_two_reg[`BIT_TRISTATE];
  // Only the two PWM codes double-buffer the compare values.
  assign pwm_mode = (compare_mode_select == `MODE_EDGE_PWM) ||
                    (compare_mode_select == `MODE_CENTER_PWM);
  // A mode write shows up one cycle later as a change against the stored code.
  assign mode_change = (compare_mode_select != last_mode_reg);
  // Access-phase decode; the master holds its request, so a write lands twice harmlessly.
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;
  assign wr_one = wr_access & (paddr == `ADDR_CONTROL_ONE);
  assign wr_two = wr_access & (paddr == `ADDR_CONTROL_TWO);
  assign addr_mapped = (paddr == `ADDR_CONTROL_ONE) || (paddr == `ADDR_CONTROL_TWO) ||
                       (paddr == `ADDR_PRIMARY) || (paddr == `ADDR_PRIMARY_HI) ||
                       (paddr == `ADDR_SECONDARY) || (paddr == `ADDR_SECONDARY_HI) ||
                       (paddr == `ADDR_TIMER);
  // Timer readback shows only the half that takes part in the compare.
  assign timer_view = cascade_32bit_enable ? compare_timer_count :
                      {`ZERO16, compare_timer_count[15:0]};

  // Comparator; the upper half joins in only when cascaded.
  compare_match_unit u_match
  (
    .timer_value(compare_timer_count),
    .primary_value(primary_compare_value_reg),
    .secondary_value(secondary_compare_value_reg),
    .wide(cascade_32bit_enable),
    .primary_hit(primary_hit),
    .secondary_hit(secondary_hit),
    .zero_hit(zero_hit)
  );

  // Next output level per mode, evaluated every clock.
  always @*
  begin
    level_next = level_reg;
    phase_next = phase_reg;
    done_next = done_reg;
    // Match events of this cycle decide the level loaded at the coming edge.
    if (mode_change)
    begin
      // A new mode starts from its initial pin state.
      // Events that fall in the cycle of a mode change are ignored on purpose.
      phase_next = 1'b0;
      done_next = 1'b0;
      level_next = (compare_mode_select == `MODE_SHOT_LOW) ? 1'b1 : 1'b0;
    end
    else
    begin
      case (compare_mode_select)
        `MODE_OFF:
        begin
          // Disabled: the level is forced low.
          level_next = 1'b0;
        end
        `MODE_SHOT_HIGH:
        begin
          // Rise once on the first primary match.
          if (primary_hit && !done_reg)
          begin
            level_next = 1'b1;
            done_next = 1'b1;
          end
        end
        `MODE_SHOT_LOW:
        begin
          // Fall once on the first primary match.
          if (primary_hit && !done_reg)
          begin
            level_next = 1'b0;
            done_next = 1'b1;
          end
        end
        `MODE_TOGGLE:
        begin
          // Invert on each primary match.
          if (primary_hit)
            level_next = ~level_reg;
        end
        `MODE_DOUBLE_SHOT:
        begin
          // Toggle on primary, then on secondary, then stop.
          if (!done_reg && !phase_reg && primary_hit)
          begin
            level_next = ~level_reg;
            phase_next = 1'b1;
          end
          else if (!done_reg && phase_reg && secondary_hit)
          begin
            level_next = ~level_reg;
            done_next = 1'b1;
          end
        end
        `MODE_DOUBLE_CONT:
        begin
          // Toggle on alternate primary and secondary matches forever.
          if (!phase_reg && primary_hit)
          begin
            level_next = ~level_reg;
            phase_next = 1'b1;
          end
          else if (phase_reg && secondary_hit)
          begin
            level_next = ~level_reg;
            phase_next = 1'b0;
          end
        end
        `MODE_EDGE_PWM:
        begin
          // Primary match wins over zero so a zero duty stays low.
          if (primary_hit)
            level_next = 1'b0;
          else if (zero_hit)
            level_next = 1'b1;
        end
        `MODE_CENTER_PWM:
        begin
          // Secondary match wins if both values are equal.
          if (secondary_hit)
            level_next = 1'b0;
          else if (primary_hit)
            level_next = 1'b1;
        end
        default:
        begin
          level_next = level_reg;
        end
      endcase
    end
  end

  // Mode state and pin drive; the pin follows the match on the same edge's result.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg <= 1'b0;
      phase_reg <= 1'b0;
      done_reg <= 1'b0;
      last_mode_reg <= `MODE_OFF;
      compare_output_pin <= 1'b0;
      compare_output_pin_oe_n <= 1'b1;
    end
    else
    begin
      level_reg <= level_next;
      phase_reg <= phase_next;
      done_reg <= done_next;
      last_mode_reg <= compare_mode_select;
      // Inversion comes after the mode logic, so every mode keeps its own start level.
      compare_output_pin <= level_next ^ output_invert;
      // Pin floats while tri-stated or disabled.
      compare_output_pin_oe_n <= output_tristate | (compare_mode_select == `MODE_OFF);
    end
  end

  // Compare value buffers: in PWM modes new values load only at the period start or on a mode change.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_compare_value_reg <= {`ZERO16, `ZERO16};
      secondary_compare_value_reg <= {`ZERO16, `ZERO16};
    end
    else if (!pwm_mode || zero_hit || mode_change)
    begin
      // Outside PWM the written value is used at once.
      // Loading at the period start keeps a mid-period write from cutting a pulse short.
      // Loading on a mode change keeps stale values of an earlier mode out of PWM.
      primary_compare_value_reg <= primary_write_reg;
      secondary_compare_value_reg <= secondary_write_reg;
    end
  end

  // Register writes and the trigger status flag.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_control_one_reg <= `RESET_CONTROL_ONE;
      compare_control_two_reg <= `RESET_CONTROL_TWO;
      primary_write_reg <= {`ZERO16, `ZERO16};
      secondary_write_reg <= {`ZERO16, `ZERO16};
    end
    else
    begin
      if (wr_one)
        compare_control_one_reg <= pwdata[15:0] & `MASK_CONTROL_ONE;
      if (wr_two)
      begin
        // Software may clear or set the flag with a write.
        compare_control_two_reg <= pwdata[15:0] & `MASK_CONTROL_TWO;
        if (compare_mode_select != `MODE_OFF && primary_hit)
          compare_control_two_reg[`BIT_TRIG_FLAG] <= 1'b1;
      end
      else if (compare_mode_select != `MODE_OFF && primary_hit)
      begin
        // A trigger event sets the flag; set wins over any clear.
        compare_control_two_reg[`BIT_TRIG_FLAG] <= 1'b1;
      end
      // A hardware clear is dropped when a set or a write to the second control register falls in the same cycle.
      else if (trigger_status_clear_mode && secondary_hit &&
               compare_mode_select != `MODE_OFF)
      begin
        // Hardware clear on secondary match when enabled.
        compare_control_two_reg[`BIT_TRIG_FLAG] <= 1'b0;
      end
      // Upper halves take part in the compare only while the channel is cascaded.
      if (wr_access && paddr == `ADDR_PRIMARY)
        primary_write_reg[15:0] <= pwdata[15:0];
      if (wr_access && paddr == `ADDR_PRIMARY_HI)
        primary_write_reg[31:16] <= pwdata[15:0];
      if (wr_access && paddr == `ADDR_SECONDARY)
        secondary_write_reg[15:0] <= pwdata[15:0];
      if (wr_access && paddr == `ADDR_SECONDARY_HI)
        secondary_write_reg[31:16] <= pwdata[15:0];
    end
  end

  // Read mux; unmapped addresses read zero with an error.
  always @*
  begin
    // Compare values read back as written, not as buffered.
    read_value = {`ZERO16, `ZERO16};
    case (paddr)
      `ADDR_CONTROL_ONE: read_value = {`ZERO16, compare_control_one_reg};
      `ADDR_CONTROL_TWO: read_value = {`ZERO16, compare_control_two_reg};
      `ADDR_PRIMARY: read_value = {`ZERO16, primary_write_reg[15:0]};
      `ADDR_PRIMARY_HI: read_value = {`ZERO16, primary_write_reg[31:16]};
      `ADDR_SECONDARY: read_value = {`ZERO16, secondary_write_reg[15:0]};
      `ADDR_SECONDARY_HI: read_value = {`ZERO16, secondary_write_reg[31:16]};
      `ADDR_TIMER: read_value = timer_view;
      default: read_value = {`ZERO16, `ZERO16};
    endcase
  end

  // APB answer: one wait state, ready pulses in the second access cycle.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {`ZERO16, `ZERO16};
    end
    else if (psel && penable && !pready)
    begin
      // Ready drops at the edge where the master samples it, so each access answers once.
      pready <= 1'b1;
      // Unmapped addresses answer with an error; read data and error stand one cycle.
      pslverr <= !addr_mapped;
      prdata <= rd_access ? read_value : {`ZERO16, `ZERO16};
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {`ZERO16, `ZERO16};
    end
  end
endmodule

/* File: verif/output_compare_channel_monitor.sv */
`timescale 1ns/1ps
// Checks the bus handshake and the pin against shadows of the control writes.
module output_compare_channel_monitor
(
  // Clock and reset.
  input logic core_clk,
  input logic rst_n,
  // Register bus.
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Timer and pin.
  input logic [31:0] compare_timer_count,
  input logic compare_output_pin,
  input logic compare_output_pin_oe_n
);
  logic [2:0] mode_reg; // Shadow of the mode code.
  logic inv_reg; // Shadow of the invert bit.
  logic wide_reg; // Shadow of the cascade bit.
  logic [15:0] pri_reg; // Shadow of the low primary value.
  logic calm_reg; // High when no write was on the bus at the last edge.
  logic calm; // High when settings cannot be in motion.
  logic hit; // Narrow primary match this cycle.
  assign calm = !(psel && pwrite) && calm_reg;
  assign hit = calm && !wide_reg && compare_timer_count[15:0] == pri_reg;
  // The shadows take every write the way the design does.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= 3'h0;
      inv_reg <= 1'b0;
      wide_reg <= 1'b0;
      pri_reg <= 16'h0000;
      calm_reg <= 1'b1;
    end
    else
    begin
      calm_reg <= !(psel && pwrite);
      if (psel && penable && pwrite && paddr == 12'h000)
        mode_reg <= pwdata[2:0];
      if (psel && penable && pwrite && paddr == 12'h004)
      begin
        inv_reg <= pwdata[12];
        wide_reg <= pwdata[8];
      end
      if (psel && penable && pwrite && paddr == 12'h008)
        pri_reg <= pwdata[15:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (psel && penable && !pready |=>
    pready && pslverr == !($past(paddr) inside {12'h000, 12'h004, 12'h008, 12'h00c,
    12'h010, 12'h014, 12'h018}))
    else $error("error response wrong for address");
  a_idle_bus: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside answer");
  a_toggle_match: assert property (mode_reg == 3'h3 && hit |=>
    compare_output_pin != $past(compare_output_pin))
    else $error("toggle mode missed a match");
  a_shot_high: assert property (mode_reg == 3'h1 && hit |=>
    compare_output_pin == !inv_reg)
    else $error("rising shot wrong");
  a_shot_low: assert property (mode_reg == 3'h2 && hit |=>
    compare_output_pin == inv_reg)
    else $error("falling shot wrong");
  a_pwm_start: assert property (mode_reg == 3'h6 && calm && !wide_reg
    && compare_timer_count[15:0] == 16'h0000 && pri_reg != 16'h0000
    |=> compare_output_pin == !inv_reg)
    else $error("edge pwm did not rise at zero");
  a_off_quiet: assert property (mode_reg == 3'h0 && $past(mode_reg) == 3'h0 && calm
    |-> compare_output_pin_oe_n && compare_output_pin == inv_reg)
    else $error("disabled channel drives");
endmodule
bind output_compare_channel output_compare_channel_monitor output_compare_channel_monitor_i
(.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
 .pslverr, .compare_timer_count, .compare_output_pin, .compare_output_pin_oe_n);

/* File: verif/compare_load_model.sv */
`timescale 1ns/1ps
// External load on the compare pin, held by a weak pull-down.
module compare_load_model
(
  // Pin drive from the channel.
  input logic pin,
  input logic pin_oe_n,
  // Level that the load sees.
  output logic level
);
  // A released pin falls to the pull-down level.
  assign level = pin_oe_n ? 1'b0 : pin;
endmodule

/* File: verif/output_compare_channel_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the compare channel.
module output_compare_channel_test;
  logic core_clk = 1'b0; // Bench clock.
  logic rst_n = 1'b0; // Reset, held low at start.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] tmr = 32'hffffffff; // Timer count; all ones matches nothing.
  wire [31:0] prdata;
  wire pready, pslverr, pin, oe_n, level;
  logic [31:0] rdat; // Read data of the last transfer.
  logic err; // Error flag of the last transfer.
  int failures = 0;
  int checks_done = 0;
  output_compare_channel output_compare_channel_i (.core_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .compare_timer_count(tmr),
    .compare_output_pin(pin), .compare_output_pin_oe_n(oe_n));
  compare_load_model compare_load_model_i (.pin(pin), .pin_oe_n(oe_n), .level(level));
  // Clock at 40 MHz.
  initial forever #12.5 core_clk = ~core_clk;
  // Compares one value and counts the result.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus transfer; the request holds until ready is seen at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 40)
      chk(32'h1, 32'h0);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Shows one timer value for a single cycle.
  task step(input logic [31:0] v);
    @(posedge core_clk);
    tmr <= v;
    @(posedge core_clk);
    tmr <= 32'hffffffff;
    #1;
  endtask
  task ts(input logic [31:0] v, input logic e);
    step(v);
    chk(pin, e);
  endtask
  // Reset values and two unmapped addresses.
  task t_reset;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'hc);
    chk(oe_n, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h002, 32'h0);
    chk(err, 1'b1);
  endtask
  // Both single-shot modes and toggling.
  task t_single;
    wr(12'h008, 32'h5);
    wr(12'h000, 32'h1);
    ts(32'h7, 1'b0);
    ts(32'h5, 1'b1);
    chk(level, 1'b1);
    wr(12'h000, 32'h2);
    ts(32'h7, 1'b1);
    ts(32'h5, 1'b0);
    ts(32'h5, 1'b0);
    wr(12'h000, 32'h3);
    ts(32'h00030005, 1'b1);
    ts(32'h5, 1'b0);
    ts(32'h6, 1'b0);
  endtask
  // Double compare, single shot then continuous.
  task t_double;
    wr(12'h00c, 32'h9);
    wr(12'h000, 32'h4);
    ts(32'h5, 1'b1);
    ts(32'h9, 1'b0);
    ts(32'h5, 1'b0);
    wr(12'h000, 32'h5);
    ts(32'h5, 1'b1);
    ts(32'h5, 1'b1);
    ts(32'h9, 1'b0);
    ts(32'h5, 1'b1);
  endtask
  // Trigger flag under both clear policies, then the disabled mode.
  task t_flag;
    wr(12'h000, 32'h3);
    step(32'h5);
    step(32'h9);
    rd(12'h004, 32'h4c);
    wr(12'h004, 32'hc);
    rd(12'h004, 32'hc);
    wr(12'h000, 32'hb);
    step(32'h5);
    rd(12'h004, 32'h4c);
    step(32'h9);
    rd(12'h004, 32'hc);
    wr(12'h000, 32'h0);
    step(32'h5);
    rd(12'h004, 32'hc);
    chk(oe_n, 1'b1);
    chk(level, 1'b0);
  endtask
  // Edge and centre PWM with buffered values.
  task t_pwm;
    wr(12'h000, 32'h6);
    ts(32'h0, 1'b1);
    wr(12'h008, 32'h7);
    ts(32'h7, 1'b1);
    ts(32'h5, 1'b0);
    ts(32'h0, 1'b1);
    ts(32'h7, 1'b0);
    wr(12'h000, 32'h7);
    ts(32'h7, 1'b1);
    ts(32'h9, 1'b0);
  endtask
  // Inverted drive, released pin, and the cascaded compare.
  task t_invert;
    wr(12'h004, 32'h100c);
    wr(12'h000, 32'h1);
    ts(32'h5, 1'b1);
    chk(oe_n, 1'b0);
    ts(32'h7, 1'b0);
    wr(12'h004, 32'h102c);
    step(32'h5);
    chk(oe_n, 1'b1);
    chk(level, 1'b0);
    wr(12'h004, 32'h10c);
    wr(12'h018, 32'h1);
    wr(12'h000, 32'h0);
    wr(12'h000, 32'h1);
    ts(32'h7, 1'b0);
    ts(32'h00010007, 1'b1);
  endtask
  // Reset in mid-run returns the pin and the registers to rest.
  task t_rerun;
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(oe_n, 1'b1);
    chk(pin, 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'hc);
    rd(12'h018, 32'h0);
  endtask
  // Cuts a hang short.
  initial
  begin
    #500000;
    failures++;
    end_sim;
  end
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_single;
    t_double;
    t_flag;
    t_pwm;
    t_invert;
    t_rerun;
    end_sim;
  end
endmodule
